// ===== core/adc_pkg.sv
package adc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RES_W = 12;
  localparam int PINS = 2;

  // Register offsets
  localparam logic [3:0] OFF_CONV_CONTROL = 4'h0;
  localparam logic [3:0] OFF_CONV_CLOCK = 4'h1;
  localparam logic [3:0] OFF_RESULT_LOW = 4'h2;
  localparam logic [3:0] OFF_RESULT_HIGH = 4'h3;
  localparam logic [3:0] OFF_IRQ_CONTROL = 4'h4;
  localparam logic [3:0] OFF_PORT_DIR = 4'h5;
  localparam logic [3:0] OFF_PORT_PULL = 4'h6;
  localparam logic [3:0] OFF_PORT_DATA = 4'h7;
  localparam logic [3:0] OFF_PORT_PINS = 4'h8;

  // Field positions
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_DONE_BIT = 6;
  localparam int CTRL_PSEL_LSB = 3;
  localparam int CTRL_CH_LSB = 0;
  localparam int CLK_OFF_BIT = 7;
  localparam int CLK_DIV_LSB = 0;
  localparam int IRQ_GLOBAL_BIT = 0;
  localparam int IRQ_MF1_BIT = 1;
  localparam int IRQ_CONV_EN_BIT = 2;
  localparam int IRQ_FLAG_BIT = 3;
  localparam int RES_LOW_LSB = 4;

  // Reset values
  localparam logic [2:0] PSEL_RST = 3'h0;
  localparam logic [2:0] CH_RST = 3'h0;
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic OFF_RST = 1'b1;
  localparam logic [1:0] DIR_RST = 2'h3;

  // Divider codes and ratios
  localparam logic [2:0] DIV_CODE_2 = 3'h0;
  localparam logic [2:0] DIV_CODE_8 = 3'h1;
  localparam logic [2:0] DIV_CODE_32 = 3'h2;
  localparam logic [5:0] RATIO_2 = 6'h02;
  localparam logic [5:0] RATIO_8 = 6'h08;
  localparam logic [5:0] RATIO_32 = 6'h20;

  // Conversion timing in converter clock periods
  localparam logic [4:0] CONV_PERIODS = 5'h10;
  localparam logic [3:0] SAMPLE_PERIODS = 4'h4;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01
  } seq_state_t;

  typedef struct packed {
    logic start;
    logic [2:0] pin_analog_select;
    logic [2:0] channel_select;
  } ctrl_t;

  typedef struct packed {
    logic conv_power_off;
    logic [2:0] conv_clock_divider;
  } clk_cfg_t;

  typedef struct packed {
    logic global_irq_enable;
    logic multi_function_irq1_enable;
    logic conv_irq_enable;
    logic conv_irq_flag;
  } irq_cfg_t;

  // Pins taken as converter inputs for a pin select code
  function automatic logic [1:0] analog_pins(input logic [2:0] psel);
    logic [1:0] m;
    m = 2'h0;
    case (psel)
      3'h0: m = 2'h0;
      3'h1: m = 2'h1;
      default: m = 2'h3;
    endcase
    return m;
  endfunction

endpackage

// ===== core/conv_clock_div.sv
`timescale 1ns/1ps
module conv_clock_div #(
  parameter int CNT_W = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [2:0] code,
  output logic tick
);

  logic [CNT_W-1:0] cnt_q, cnt_d, ratio;
  logic tick_q, tick_d;

  always_comb
  begin
    case (code)
      adc_pkg::DIV_CODE_2: ratio = CNT_W'(adc_pkg::RATIO_2);
      adc_pkg::DIV_CODE_8: ratio = CNT_W'(adc_pkg::RATIO_8);
      default: ratio = CNT_W'(adc_pkg::RATIO_32);
    endcase
    cnt_d = cnt_q + 1'b1;
    tick_d = 1'b0;
    if (clear)
    begin
      cnt_d = '0;
    end
    else if (cnt_q >= ratio - 1'b1) // [RULE16]
    begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

  property p_div8;
    @(posedge clk) disable iff (!rst_n)
    (tick_q && code == adc_pkg::DIV_CODE_8 && !clear) ##1
    (!clear && code == adc_pkg::DIV_CODE_8) [*7] |=> tick_q;
  endproperty
  a_div8: assert property (p_div8) // [RULE16]
    else $error("Divide by 8 tick spacing wrong");

endmodule

// ===== core/conv_sequencer.sv
`timescale 1ns/1ps
module conv_sequencer #(
  parameter int RES_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic hold,
  input wire logic launch,
  input wire logic [RES_W-1:0] sample,
  output logic busy,
  output logic done,
  output logic [RES_W-1:0] result
);

  adc_pkg::seq_state_t state_q, state_d;
  logic [3:0] period_q, period_d;
  logic [RES_W-1:0] held_q, held_d, res_q, res_d, trial;
  logic done_q, done_d;
  logic [3:0] bit_idx;

  // Runs alone once launched; software is never stalled
  always_comb
  begin
    state_d = state_q;
    period_d = period_q;
    held_d = held_q;
    res_d = res_q;
    done_d = 1'b0;
    bit_idx = 4'hF - period_q;
    trial = res_q | (RES_W'(1) << bit_idx);
    case (state_q) // [RULE8]
      adc_pkg::SEQ_IDLE:
      begin
        if (launch && !hold)
        begin
          state_d = adc_pkg::SEQ_CONV;
          period_d = 4'h0;
          res_d = '0;
        end
      end
      adc_pkg::SEQ_CONV:
      begin
        if (hold)
        begin
          state_d = adc_pkg::SEQ_IDLE;
        end
        else if (tick)
        begin
          if (period_q < adc_pkg::SAMPLE_PERIODS)
          begin
            held_d = sample;
          end
          else if (held_q >= trial) // [RULE15]
          begin
            res_d = trial;
          end
          period_d = period_q + 4'h1;
          if (period_q == 4'(adc_pkg::CONV_PERIODS - 5'h01)) // [RULE7]
          begin
            state_d = adc_pkg::SEQ_IDLE;
            done_d = 1'b1;
            if (held_q >= trial)
            begin
              res_d = trial;
            end
          end
        end
      end
      default: state_d = adc_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= adc_pkg::SEQ_IDLE;
      period_q <= 4'h0;
      held_q <= '0;
      res_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      period_q <= period_d;
      held_q <= held_d;
      res_q <= res_d;
      done_q <= done_d;
    end
  end

  assign busy = (state_q == adc_pkg::SEQ_CONV);
  assign done = done_q;
  assign result = res_q;

  logic [4:0] ticks_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ticks_q <= 5'h00;
    else if (launch && state_q == adc_pkg::SEQ_IDLE)
      ticks_q <= 5'h00;
    else if (tick && busy)
      ticks_q <= ticks_q + 5'h01;
  end

  property p_conv_len;
    @(posedge clk) disable iff (!rst_n)
    done_q |-> ticks_q == adc_pkg::CONV_PERIODS;
  endproperty
  a_conv_len: assert property (p_conv_len) // [RULE7]
    else $error("Conversion did not take sixteen periods");

endmodule

// ===== core/adc_conversion_control.sv
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Function
// [RULE1] Analog-selected pin ignores its direction bit and is never driven.
// [RULE2] Pull-high is removed from any pin used as converter input.
// [RULE3] Software pulses start within one to ten cycles after selection change.
// [RULE4] A start pulse sets the active-low done flag high.
// [RULE5] Start going 0 to 1 to 0 launches a conversion.
// [RULE6] Done flag goes low at completion with result registers valid.
// [RULE7] A conversion lasts sixteen converter clock periods.
// [RULE8] Conversion runs in hardware; the processor is never stalled.
// [RULE9] Interrupt only when global, group 1 and converter enables set.
// [RULE10] Pin select zero: all pins normal I/O, converter powered down.
// [RULE11] No start pulse needed when channel bits become all zero.
// [RULE12] Power-off bit powers converter down regardless of pin select.
// [RULE13] Software sets divider, power, channel, pins before starting.
// [RULE14] Channel field routes exactly one input to the converter; channel codes 2 to 7 route none.
// [RULE15] Result is 12-bit unsigned, full scale FFF, step reference/4096.
// [RULE16] Divider codes 000, 001, 010 give divide by 2, 8, 32.
// [RULE17] Converter on only with nonzero pin select and power-off clear.
// [RULE18] Start left high holds converter reset and done flag high.
// [RULE19] Completion sets interrupt flag; high byte 11..4, low nibble 3..0.
// [RULE20] Interrupt flag stays set until software clears it.
module adc_conversion_control #(
  parameter int RES_W = 12
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [1:0] PB_IN,
  output logic [1:0] PB_OUT,
  output logic [1:0] PB_OE_N,
  output logic [1:0] PB_PULL_EN,
  input wire logic [RES_W-1:0] AIN_CODE,
  output logic [1:0] ANA_CH_SEL,
  output logic ANA_POWER_EN,
  output logic IRQ
);

  adc_pkg::ctrl_t ctrl_q, ctrl_d;
  adc_pkg::clk_cfg_t clk_q, clk_d;
  adc_pkg::irq_cfg_t irq_q, irq_d;
  logic conv_done_n_q, conv_done_n_d;
  logic [RES_W-1:0] res_q, res_d;
  logic [1:0] port_b_direction_q, port_b_direction_d;
  logic [1:0] pull_q, pull_d;
  logic [1:0] pdata_q, pdata_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] pb_out_q, pb_out_d, pb_oe_n_q, pb_oe_n_d;
  logic [1:0] pb_pull_q, pb_pull_d, ch_sel_q, ch_sel_d;
  logic power_q, power_d, irq_out_q, irq_out_d;
  logic [1:0] pin_s1_q, pin_s2_q;
  logic [RES_W-1:0] ain_s1_q, ain_s2_q;
  logic wr_ctrl, wr_clk, wr_irq, launch, conv_on, hold;
  logic tick, seq_busy, seq_done;
  logic [RES_W-1:0] seq_result;
  logic [1:0] analog;

  // Decode of a write to a given offset
  function automatic logic wr_hit(input logic w, input logic [3:0] a,
                                  input logic [3:0] off);
    return w && (a == off);
  endfunction

  assign wr_ctrl = wr_hit(WR, ADDR, adc_pkg::OFF_CONV_CONTROL);
  assign wr_clk = wr_hit(WR, ADDR, adc_pkg::OFF_CONV_CLOCK);
  assign wr_irq = wr_hit(WR, ADDR, adc_pkg::OFF_IRQ_CONTROL);
  assign analog = adc_pkg::analog_pins(ctrl_q.pin_analog_select);

  // Converter enable from pin select and power-off bit
  assign conv_on = (ctrl_q.pin_analog_select != 3'h0) &&
                   !clk_q.conv_power_off; // [RULE10] [RULE12] [RULE17]

  // Falling edge of the start bit written by software
  assign launch = wr_ctrl && ctrl_q.start &&
                  !WDATA[adc_pkg::CTRL_START_BIT]; // [RULE5]
  assign hold = (ctrl_q.start && !launch) ||
                !conv_on; // [RULE11] [RULE18]

  // Synchronisers for pins and analog front-end code
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      ain_s1_q <= '0;
      ain_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= PB_IN;
      pin_s2_q <= pin_s1_q;
      ain_s1_q <= AIN_CODE;
      ain_s2_q <= ain_s1_q;
    end
  end

  conv_clock_div #(
    .CNT_W(6)
  ) u_div (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(hold || !seq_busy),
    .code(clk_q.conv_clock_divider),
    .tick(tick)
  );

  conv_sequencer #(
    .RES_W(RES_W)
  ) u_seq (
    .clk(MCLK),
    .rst_n(RST_N),
    .tick(tick),
    .hold(hold),
    .launch(launch && conv_on),
    .sample(ain_s2_q),
    .busy(seq_busy),
    .done(seq_done),
    .result(seq_result)
  );

  // Register file next state
  always_comb
  begin
    ctrl_d = ctrl_q;
    clk_d = clk_q;
    irq_d = irq_q;
    conv_done_n_d = conv_done_n_q;
    res_d = res_q;
    port_b_direction_d = port_b_direction_q;
    pull_d = pull_q;
    pdata_d = pdata_q;
    if (wr_ctrl)
    begin
      ctrl_d.start = WDATA[adc_pkg::CTRL_START_BIT];
      ctrl_d.pin_analog_select = WDATA[adc_pkg::CTRL_PSEL_LSB +: 3];
      ctrl_d.channel_select = WDATA[adc_pkg::CTRL_CH_LSB +: 3];
    end
    if (wr_clk)
    begin
      clk_d.conv_power_off = WDATA[adc_pkg::CLK_OFF_BIT];
      clk_d.conv_clock_divider = WDATA[adc_pkg::CLK_DIV_LSB +: 3];
    end
    if (wr_irq)
    begin
      irq_d.global_irq_enable = WDATA[adc_pkg::IRQ_GLOBAL_BIT];
      irq_d.multi_function_irq1_enable = WDATA[adc_pkg::IRQ_MF1_BIT];
      irq_d.conv_irq_enable = WDATA[adc_pkg::IRQ_CONV_EN_BIT];
      irq_d.conv_irq_flag = WDATA[adc_pkg::IRQ_FLAG_BIT]; // [RULE20]
    end
    if (wr_hit(WR, ADDR, adc_pkg::OFF_PORT_DIR))
      port_b_direction_d = WDATA[1:0];
    if (wr_hit(WR, ADDR, adc_pkg::OFF_PORT_PULL))
      pull_d = WDATA[1:0];
    if (wr_hit(WR, ADDR, adc_pkg::OFF_PORT_DATA))
      pdata_d = WDATA[1:0];
    if (wr_ctrl && WDATA[adc_pkg::CTRL_START_BIT])
      conv_done_n_d = 1'b1; // [RULE4] [RULE18]
    else if (seq_done)
    begin
      conv_done_n_d = 1'b0; // [RULE6]
      res_d = seq_result;
    end
    if (seq_done)
      irq_d.conv_irq_flag = 1'b1; // [RULE19]
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_q <= '{1'b0, adc_pkg::PSEL_RST, adc_pkg::CH_RST};
      clk_q <= '{adc_pkg::OFF_RST, adc_pkg::DIV_RST};
      irq_q <= '0;
      conv_done_n_q <= 1'b1;
      res_q <= '0;
      port_b_direction_q <= adc_pkg::DIR_RST;
      pull_q <= 2'h0;
      pdata_q <= 2'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      clk_q <= clk_d;
      irq_q <= irq_d;
      conv_done_n_q <= conv_done_n_d;
      res_q <= res_d;
      port_b_direction_q <= port_b_direction_d;
      pull_q <= pull_d;
      pdata_q <= pdata_d;
    end
  end

  // Read data, pins, analog controls and interrupt output
  always_comb
  begin
    rdata_d = 8'h00;
    if (RD)
    begin
      case (ADDR)
        adc_pkg::OFF_CONV_CONTROL:
          rdata_d = {ctrl_q.start, conv_done_n_q,
                     ctrl_q.pin_analog_select, ctrl_q.channel_select};
        adc_pkg::OFF_CONV_CLOCK:
          rdata_d = {clk_q.conv_power_off, 4'h0,
                     clk_q.conv_clock_divider};
        adc_pkg::OFF_RESULT_LOW:
          rdata_d = {res_q[3:0], 4'h0}; // [RULE19]
        adc_pkg::OFF_RESULT_HIGH:
          rdata_d = res_q[RES_W-1:4]; // [RULE19]
        adc_pkg::OFF_IRQ_CONTROL:
          rdata_d = {4'h0, irq_q.conv_irq_flag, irq_q.conv_irq_enable,
                     irq_q.multi_function_irq1_enable,
                     irq_q.global_irq_enable};
        adc_pkg::OFF_PORT_DIR: rdata_d = {6'h00, port_b_direction_q};
        adc_pkg::OFF_PORT_PULL: rdata_d = {6'h00, pull_q};
        adc_pkg::OFF_PORT_DATA: rdata_d = {6'h00, pdata_q};
        adc_pkg::OFF_PORT_PINS: rdata_d = {6'h00, pin_s2_q & ~analog};
        default: rdata_d = 8'h00;
      endcase
    end
    pb_out_d = pdata_q;
    pb_oe_n_d = port_b_direction_q | analog; // [RULE1]
    pb_pull_d = pull_q & port_b_direction_q & ~analog; // [RULE2]
    case (ctrl_q.channel_select) // [RULE14]
      3'h0: ch_sel_d = conv_on ? 2'h1 : 2'h0;
      3'h1: ch_sel_d = conv_on ? 2'h2 : 2'h0;
      default: ch_sel_d = 2'h0;
    endcase
    power_d = conv_on; // [RULE10] [RULE12]
    irq_out_d = irq_q.conv_irq_flag && irq_q.global_irq_enable &&
                irq_q.multi_function_irq1_enable &&
                irq_q.conv_irq_enable; // [RULE9]
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rdata_q <= 8'h00;
      pb_out_q <= 2'h0;
      pb_oe_n_q <= 2'h3;
      pb_pull_q <= 2'h0;
      ch_sel_q <= 2'h0;
      power_q <= 1'b0;
      irq_out_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      pb_out_q <= pb_out_d;
      pb_oe_n_q <= pb_oe_n_d;
      pb_pull_q <= pb_pull_d;
      ch_sel_q <= ch_sel_d;
      power_q <= power_d;
      irq_out_q <= irq_out_d;
    end
  end

  assign RDATA = rdata_q;
  assign PB_OUT = pb_out_q;
  assign PB_OE_N = pb_oe_n_q;
  assign PB_PULL_EN = pb_pull_q;
  assign ANA_CH_SEL = ch_sel_q;
  assign ANA_POWER_EN = power_q;
  assign IRQ = irq_out_q;

  property p_analog_oe;
    @(posedge MCLK) disable iff (!RST_N)
    analog[0] && $stable(analog) |=> PB_OE_N[0];
  endproperty
  a_analog_oe: assert property (p_analog_oe) // [RULE1]
    else $error("Analog pin is being driven");

  property p_pull_off;
    @(posedge MCLK) disable iff (!RST_N)
    analog[1] |=> !PB_PULL_EN[1];
  endproperty
  a_pull_off: assert property (p_pull_off) // [RULE2]
    else $error("Pull-high left on an analog pin");

  property p_reinit;
    @(posedge MCLK) disable iff (!RST_N)
    wr_ctrl && WDATA[adc_pkg::CTRL_START_BIT] |=> conv_done_n_q;
  endproperty
  a_reinit: assert property (p_reinit) // [RULE4]
    else $error("Start pulse did not set done flag high");

  property p_launch;
    @(posedge MCLK) disable iff (!RST_N)
    launch && conv_on |=> seq_busy && conv_done_n_q;
  endproperty
  a_launch: assert property (p_launch) // [RULE5]
    else $error("Start sequence did not launch conversion");

  property p_done;
    @(posedge MCLK) disable iff (!RST_N)
    seq_done && !wr_ctrl |=> !conv_done_n_q && res_q == $past(seq_result);
  endproperty
  a_done: assert property (p_done) // [RULE6]
    else $error("Completion did not clear done flag or load result");

  property p_irq;
    @(posedge MCLK) disable iff (!RST_N)
    ##1 IRQ == $past(irq_q.conv_irq_flag && irq_q.global_irq_enable &&
                     irq_q.multi_function_irq1_enable &&
                     irq_q.conv_irq_enable);
  endproperty
  a_irq: assert property (p_irq) // [RULE9]
    else $error("Interrupt output does not follow enables");

  property p_power;
    @(posedge MCLK) disable iff (!RST_N)
    (ctrl_q.pin_analog_select == 3'h0 || clk_q.conv_power_off)
    |=> !ANA_POWER_EN && ANA_CH_SEL == 2'h0;
  endproperty
  a_power: assert property (p_power) // [RULE10] [RULE12] [RULE17]
    else $error("Converter powered while disabled");

  property p_onehot;
    @(posedge MCLK) disable iff (!RST_N)
    $onehot0(ANA_CH_SEL);
  endproperty
  a_onehot: assert property (p_onehot) // [RULE14]
    else $error("More than one channel routed");

  property p_hold;
    @(posedge MCLK) disable iff (!RST_N)
    ctrl_q.start [*2] |-> conv_done_n_q && !seq_busy;
  endproperty
  a_hold: assert property (p_hold) // [RULE18]
    else $error("Converter not held while start high");

  property p_flag;
    @(posedge MCLK) disable iff (!RST_N)
    seq_done |=> irq_q.conv_irq_flag;
  endproperty
  a_flag: assert property (p_flag) // [RULE19] [RULE20]
    else $error("Completion did not set interrupt flag");

endmodule

// ===== tb/analog_pin_model.sv
`timescale 1ns/1ps
module analog_pin_model (
  input wire logic clk,
  input wire logic [1:0] pb_out,
  input wire logic [1:0] pb_oe_n,
  input wire logic [1:0] pb_pull_en,
  input wire logic [1:0] ana_ch_sel,
  input wire logic ana_power_en,
  input wire logic [11:0] level0,
  input wire logic [11:0] level1,
  output logic [1:0] pb_in,
  output logic [11:0] ain_code
);
  logic flip = 1'b0;

  always @(posedge clk) flip <= ~flip;

  // Pin level from every driver; an undriven pin wanders
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!pb_oe_n[i])
        pb_in[i] = pb_out[i];
      else if (pb_pull_en[i])
        pb_in[i] = 1'b1;
      else
        pb_in[i] = flip;
    end
  end

  // Only a powered front end with one routed input gives a level
  always_comb
  begin
    if (ana_power_en && ana_ch_sel == 2'b01)
      ain_code = level0;
    else if (ana_power_en && ana_ch_sel == 2'b10)
      ain_code = level1;
    else
      ain_code = {12{flip}};
  end
endmodule

// ===== tb/test_adc_conversion_control.sv
`timescale 1ns/1ps
module test_adc_conversion_control;
  logic MCLK, RST_N, WR, RD;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA;
  logic [1:0] PB_IN, PB_OUT, PB_OE_N, PB_PULL_EN, ANA_CH_SEL;
  logic [11:0] AIN_CODE, level0, level1;
  logic ANA_POWER_EN, IRQ;
  int fails, total_checks, cyc;
  localparam logic [3:0] CTL = adc_pkg::OFF_CONV_CONTROL;
  localparam logic [3:0] CLK = adc_pkg::OFF_CONV_CLOCK;
  localparam logic [3:0] IRQR = adc_pkg::OFF_IRQ_CONTROL;

  adc_conversion_control u_adc_conversion_control (.MCLK(MCLK),
    .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PB_IN(PB_IN), .PB_OUT(PB_OUT), .PB_OE_N(PB_OE_N),
    .PB_PULL_EN(PB_PULL_EN), .AIN_CODE(AIN_CODE), .ANA_CH_SEL(ANA_CH_SEL),
    .ANA_POWER_EN(ANA_POWER_EN), .IRQ(IRQ));

  analog_pin_model u_analog_pin_model (.clk(MCLK), .pb_out(PB_OUT),
    .pb_oe_n(PB_OE_N), .pb_pull_en(PB_PULL_EN), .ana_ch_sel(ANA_CH_SEL),
    .ana_power_en(ANA_POWER_EN), .level0(level0), .level1(level1),
    .pb_in(PB_IN), .ain_code(AIN_CODE));

  always #10 MCLK = ~MCLK;
  always @(posedge MCLK) cyc <= cyc + 1;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask

  task automatic rdchk(input string what, input logic [3:0] a,
                       input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, 12'(exp), 12'(d));
  endtask

  task automatic settle;
    repeat (3) @(posedge MCLK);
    #1;
  endtask

  // Poll the done flag; cycles counted from the launching write
  task automatic wait_done(output int took);
    logic [7:0] d;
    int t0;
    #1;
    t0 = cyc;
    d = 8'h40;
    for (int n = 0; n < 400 && d[6] === 1'b1; n++)
      rd(CTL, d);
    took = cyc - t0;
    if (d[6] !== 1'b0)
    begin
      fails++;
      $display("BAD done flag expected 0 seen %b", d[6]);
      give_verdict;
    end
  endtask

  task automatic t_reset;
    chk("oe after reset", 12'h003, 12'(PB_OE_N));
    chk("power after reset", 12'h000, 12'(ANA_POWER_EN));
    rdchk("control reset", CTL, 8'h40);
    rdchk("clock reset", CLK, 8'h80);
    rdchk("irq reset", IRQR, 8'h00);
    wr(4'hF, 8'hFF);
    wr(adc_pkg::OFF_RESULT_HIGH, 8'hFF);
    rdchk("unmapped", 4'hF, 8'h00);
    rdchk("result read only", adc_pkg::OFF_RESULT_HIGH, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_pins;
    wr(adc_pkg::OFF_PORT_PULL, 8'h03);
    wr(adc_pkg::OFF_PORT_DATA, 8'h02);
    wr(adc_pkg::OFF_PORT_DIR, 8'h01);
    settle;
    settle;
    chk("oe normal", 12'h001, 12'(PB_OE_N));
    chk("pull normal", 12'h001, 12'(PB_PULL_EN));
    chk("out normal", 12'h002, 12'(PB_OUT));
    rdchk("pin levels", adc_pkg::OFF_PORT_PINS, 8'h03);
    wr(CTL, 8'h08);
    wr(adc_pkg::OFF_PORT_DIR, 8'h00);
    settle;
    chk("oe analog", 12'h001, 12'(PB_OE_N));
    wr(adc_pkg::OFF_PORT_DIR, 8'h03);
    settle;
    chk("pull analog", 12'h002, 12'(PB_PULL_EN));
    wr(adc_pkg::OFF_PORT_DIR, 8'h00);
    wr(CTL, 8'h00);
    settle;
    chk("oe io", 12'h000, 12'(PB_OE_N));
    $display("test pins done");
  endtask

  task automatic t_conv;
    logic [2:0] code [3] = '{3'h0, 3'h1, 3'h2};
    int ratio [3] = '{2, 8, 32};
    logic [11:0] lvl [3] = '{12'hFFF, 12'h5F3, 12'hABC};
    logic ch;
    int took;
    for (int i = 0; i < 3; i++)
    begin
      ch = i[0];
      level0 <= ch ? ~lvl[i] : lvl[i];
      level1 <= ch ? lvl[i] : ~lvl[i];
      wr(CLK, {5'h00, code[i]});
      wr(CTL, {7'h48, ch});
      settle;
      chk("route", ch ? 12'h002 : 12'h001, 12'(ANA_CH_SEL));
      chk("power on", 12'h001, 12'(ANA_POWER_EN));
      wr(CTL, {7'h48, ch});
      wr(CTL, {7'h08, ch});
      wait_done(took);
      chk("conv time", 12'h001,
          12'(took >= 16 * ratio[i] && took <= 16 * ratio[i] + 6));
      rdchk("result high", adc_pkg::OFF_RESULT_HIGH, lvl[i][11:4]);
      rdchk("result low", adc_pkg::OFF_RESULT_LOW, {lvl[i][3:0], 4'h0});
      rdchk("flag set", IRQR, 8'h08);
      wr(IRQR, 8'h00);
    end
    $display("test conversion done");
  endtask

  task automatic t_hold_irq;
    int took;
    wr(CLK, 8'h00);
    wr(CTL, 8'h90);
    repeat (60) @(posedge MCLK);
    rdchk("start held", CTL, 8'hD0);
    wr(CTL, 8'h10);
    wait_done(took);
    wr(CTL, 8'h91);
    rdchk("done after pulse", CTL, 8'hD1);
    wr(CTL, 8'h11);
    wait_done(took);
    for (int en = 0; en < 8; en++)
    begin
      wr(IRQR, 8'h08 | 8'(en));
      settle;
      chk("irq line", 12'(en == 7), 12'(IRQ));
    end
    wr(IRQR, 8'h07);
    settle;
    chk("irq cleared", 12'h000, 12'(IRQ));
    rdchk("flag cleared", IRQR, 8'h07);
    $display("test hold and interrupt done");
  endtask

  task automatic t_power;
    wr(CLK, 8'h80);
    settle;
    chk("power off bit", 12'h000, 12'(ANA_POWER_EN));
    chk("route off", 12'h000, 12'(ANA_CH_SEL));
    wr(CTL, 8'h90);
    wr(CTL, 8'h10);
    repeat (60) @(posedge MCLK);
    rdchk("no launch when off", CTL, 8'h50);
    wr(CLK, 8'h00);
    wr(CTL, 8'h00);
    settle;
    chk("power no pins", 12'h000, 12'(ANA_POWER_EN));
    $display("test power done");
  endtask

  initial
  begin
    MCLK = 1'b0;
    RST_N = 1'b0;
    ADDR = 4'h0;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    level0 = 12'h000;
    level1 = 12'h000;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    repeat (20) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    #1;
    t_reset;
    t_pins;
    t_conv;
    t_hold_irq;
    t_power;
    give_verdict;
  end
endmodule
